/* hdl/dbu_defs.vh */
// Constants for the debug serial port: register offsets, field positions,
// reset values and parity encodings.
// Assumes inclusion by the port module only; definitions only.
`ifndef DBU_DEFS_VH
`define DBU_DEFS_VH

// Register byte offsets
`define DBU_CMD_OFS       8'h00
`define DBU_FMT_OFS       8'h04
`define DBU_FLAGS_OFS     8'h14
`define DBU_RXHOLD_OFS    8'h18
`define DBU_TXHOLD_OFS    8'h1c
`define DBU_BAUD_OFS      8'h20

// Command register bit positions
`define DBU_CMD_RXCLR     2
`define DBU_CMD_TXCLR     3
`define DBU_CMD_RXON      4
`define DBU_CMD_RXOFF     5
`define DBU_CMD_TXON      6
`define DBU_CMD_TXOFF     7
`define DBU_CMD_CLRERR    8

// Format register parity field position
`define DBU_FMT_PAR_LO    9
`define DBU_FMT_PAR_HI    11

// Parity kinds
`define DBU_PAR_EVEN      3'h0
`define DBU_PAR_ODD       3'h1
`define DBU_PAR_SPACE     3'h2
`define DBU_PAR_MARK      3'h3

// Flag register bit positions
`define DBU_FLG_CHAR_RECEIVED_FLAG     0
`define DBU_FLG_HOLDING_EMPTY_FLAG     1
`define DBU_FLG_OVR       5
`define DBU_FLG_FRM       6
`define DBU_FLG_PAR       7
`define DBU_FLG_ALL_SENT_FLAG   9
`define DBU_FLG_MBRD      30
`define DBU_FLG_MBWR      31

// Reset values and timing counts in sample ticks
`define DBU_FMT_RESET     3'h4
`define DBU_BAUD_RESET    16'h0000
`define DBU_OVERSAMPLE    5'h10
`define DBU_START_MIN     5'h08
`define DBU_HALF_BIT      5'h08

`endif

/* hdl/dbu_port.v */
// Debug serial port: baud generator, receiver, transmitter and registers.
// Assumes a synchronous register port and a serial input already synchronous to clk.
`timescale 1ns/1ns
`include "dbu_defs.vh"

// Summary of operation
// R1: Bit period is sixteen times divisor
// R2: Zero divisor stops ticks and port
// R3: Divisor is a 16-bit value
// R4: Receiver starts disabled; enable starts search
// R5: Receiver disable waits for stop bit
// R6: Receiver clear aborts character and disables
// R7: Start needs over seven low samples
// R8: First data sample 24 ticks after edge
// R9: Later bits sampled every sixteen ticks
// R10: Character loads holding; read clears ready
// R11: Completion while ready sets overrun
// R12: Overrun clears only by clear command
// R13: Parity mismatch flags with ready
// R14: Parity error held until clear command
// R15: Low stop bit sets framing error
// R16: Framing error held until clear command
// R17: Transmitter starts disabled; waits for character
// R18: Transmitter disable finishes pending characters
// R19: Transmitter clear halts at once
// R20: Frame: start, 8 bits LSB first, parity, stop
// R21: Asynchronous 8-bit only, no extras
// R22: Mailbox full signals visible and raise interrupt
// R23: Parity none, odd, even, space, mark
// R24: All-sent after last stop, both empty
// R25: Holding-empty clears on write, rises on load
// R26: Line high when idle, disabled or reset
// R27: Software clears all error flags together
module dbu_port (
	input  wire        clk,               // Master clock
	input  wire        reset_n,           // Asynchronous reset, active low
	input  wire        clk_en,            // Freezes all state while low
	input  wire [7:0]  addr,              // Register byte address
	input  wire [31:0] wdata,             // Write data
	input  wire        wr,                // Write strobe
	input  wire        rd,                // Read strobe
	output reg  [31:0] rdata,             // Read data, cycle after the strobe
	input  wire        serial_in_pin,     // Receive line
	output reg         serial_out_pin,    // Transmit line
	input  wire        mailbox_read_full, // Debug mailbox read register full
	input  wire        mailbox_write_full,// Debug mailbox write register full
	output wire        irq                // Interrupt request, level
);

	// Transmit states
	localparam TX_IDLE = 2'd0;
	localparam TX_SEND = 2'd1;

	// Register file
	reg  [15:0] baud_divisor_reg;         // Clock divisor value
	reg  [2:0]  check_bit_kind_field;     // Parity selection
	reg  [7:0]  rx_holding_reg;           // Last received character
	reg  [7:0]  tx_holding_reg;           // Character waiting to send
	reg  [31:0] irq_mask;                 // Interrupt enables per flag

	// Flags
	reg         char_received_flag;       // Receive ready
	reg         overrun_flag;             // Overrun
	reg         check_bit_error_flag;     // Parity error
	reg         framing_flag;             // Framing error
	reg         hold_full;                // Transmit holding occupied

	// Baud generator
	reg  [15:0] div_cnt;                  // Prescaler counter
	wire        tick;                     // Sixteen-times-baud sample tick

	// Receiver
	reg         rx_on;                    // Receiver enabled
	reg         rx_off_pend;              // Disable waiting for stop bit
	reg         rx_busy;                  // Character in progress
	reg  [4:0]  rx_cnt;                   // Tick counter inside a bit
	reg  [3:0]  rx_bit;                   // Bit index after the start bit
	reg  [8:0]  rx_shift;                 // Data and parity bits

	// Transmitter
	reg         tx_on;                    // Transmitter enabled
	reg         tx_off_pend;              // Disable waiting for drain
	reg  [1:0]  tx_state;                 // Transmit state
	reg  [10:0] tx_shift;                 // Frame bits, LSB first
	reg  [3:0]  tx_left;                  // Bits remaining in frame
	reg  [3:0]  tx_cnt;                   // Ticks within current bit

	// Decoded commands
	wire        cmd_wr   = clk_en & wr & (addr == `DBU_CMD_OFS);
	wire        rx_clr   = cmd_wr & wdata[`DBU_CMD_RXCLR];
	wire        tx_clr   = cmd_wr & wdata[`DBU_CMD_TXCLR];
	wire        rx_onc   = cmd_wr & wdata[`DBU_CMD_RXON] & ~wdata[`DBU_CMD_RXOFF];
	wire        rx_offc  = cmd_wr & wdata[`DBU_CMD_RXOFF];
	wire        tx_onc   = cmd_wr & wdata[`DBU_CMD_TXON] & ~wdata[`DBU_CMD_TXOFF];
	wire        tx_offc  = cmd_wr & wdata[`DBU_CMD_TXOFF];
	wire        clr_err  = cmd_wr & wdata[`DBU_CMD_CLRERR];
	wire        thr_wr   = clk_en & wr & (addr == `DBU_TXHOLD_OFS);
	wire        rhr_rd   = clk_en & rd & (addr == `DBU_RXHOLD_OFS);

	// Parity enabled unless the field selects none
	wire        par_en   = (check_bit_kind_field <= `DBU_PAR_MARK);
	wire [3:0]  rx_last  = par_en ? 4'd10 : 4'd9;                    // R21

	// Expected parity bit for a data byte
	function par_bit;
		input [7:0] d;
		input [2:0] kind;
		begin
			case (kind)
				`DBU_PAR_EVEN:  par_bit = ^d;
				`DBU_PAR_ODD:   par_bit = ~(^d);
				`DBU_PAR_SPACE: par_bit = 1'b0;
				`DBU_PAR_MARK:  par_bit = 1'b1;
				default:        par_bit = 1'b0;
			endcase
		end
	endfunction

	// Status word
	wire        all_sent_flag = tx_on & ~hold_full & (tx_state == TX_IDLE);   // R24
	wire [31:0] flags = {mailbox_write_full, mailbox_read_full, 20'h0,      // R22
		all_sent_flag, 1'b0, check_bit_error_flag, framing_flag, overrun_flag,
		3'h0, tx_on & ~hold_full, char_received_flag};
	assign irq = |(flags & irq_mask);                                      // R22

	// Baud prescaler: one tick per divisor clocks, none when divisor is zero
	assign tick = clk_en & (baud_divisor_reg != 16'h0000) & (div_cnt == 16'h0001); // R1 R2
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 16'h0001;
		end else if (clk_en) begin
			if (baud_divisor_reg == 16'h0000) begin
				div_cnt <= 16'h0001;                 // R2
			end else if (div_cnt <= 16'h0001) begin
				div_cnt <= baud_divisor_reg;         // R1 R3
			end else begin
				div_cnt <= div_cnt - 16'h0001;
			end
		end
	end

	// Register writes and read data
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baud_divisor_reg     <= `DBU_BAUD_RESET;
			check_bit_kind_field <= `DBU_FMT_RESET;
			irq_mask             <= 32'h0000_0000;
			rdata                <= 32'h0000_0000;
		end else if (clk_en) begin
			// Writes
			if (wr) begin
				case (addr)
					`DBU_BAUD_OFS: baud_divisor_reg     <= wdata[15:0];                      // R3
					`DBU_FMT_OFS:  check_bit_kind_field <= wdata[`DBU_FMT_PAR_HI:`DBU_FMT_PAR_LO]; // R23
					8'h08:         irq_mask             <= irq_mask | wdata;
					8'h0c:         irq_mask             <= irq_mask & ~wdata;
					default:       irq_mask             <= irq_mask;
				endcase
			end
			// Reads: unmapped addresses read zero
			if (rd) begin
				case (addr)
					`DBU_FMT_OFS:    rdata <= {20'h0, check_bit_kind_field, 9'h0};
					8'h10:           rdata <= irq_mask;
					`DBU_FLAGS_OFS:  rdata <= flags;
					`DBU_RXHOLD_OFS: rdata <= {24'h0, rx_holding_reg};
					`DBU_BAUD_OFS:   rdata <= {16'h0, baud_divisor_reg};
					default:         rdata <= 32'h0000_0000;
				endcase
			end else begin
				rdata <= 32'h0000_0000;
			end
		end
	end

	// Receiver: start detection, mid-bit sampling, flags
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_on                <= 1'b0;            // R4
			rx_off_pend          <= 1'b0;
			rx_busy              <= 1'b0;
			rx_cnt               <= 5'h00;
			rx_bit               <= 4'h0;
			rx_shift             <= 9'h000;
			rx_holding_reg       <= 8'h00;
			char_received_flag   <= 1'b0;
			overrun_flag         <= 1'b0;
			check_bit_error_flag <= 1'b0;
			framing_flag         <= 1'b0;
		end else if (clk_en) begin
			// Error flags: clear command first, completion below may set again
			if (clr_err) begin
				overrun_flag         <= 1'b0;        // R12 R27
				check_bit_error_flag <= 1'b0;        // R14
				framing_flag         <= 1'b0;        // R16
			end
			if (rhr_rd)
				char_received_flag <= 1'b0;          // R10
			if (rx_clr) begin
				// Abort at once, data lost
				rx_on       <= 1'b0;                 // R6
				rx_off_pend <= 1'b0;
				rx_busy     <= 1'b0;
				rx_cnt      <= 5'h00;
				rx_bit      <= 4'h0;
			end else begin
				if (rx_onc) begin
					rx_on       <= 1'b1;             // R4
					rx_off_pend <= 1'b0;
				end
				if (rx_offc) begin
					if (rx_busy)
						rx_off_pend <= 1'b1;         // R5
					else begin
						rx_on   <= 1'b0;             // R5
						rx_cnt  <= 5'h00;
					end
				end
				if (tick && rx_on && !rx_busy) begin
					// Hunt: count consecutive low samples
					if (serial_in_pin) begin
						rx_cnt <= 5'h00;
					end else if (rx_cnt == `DBU_START_MIN - 5'h01) begin
						// Eighth low sample: start accepted, 16 more ticks to first mid-bit
						rx_busy <= 1'b1;             // R7 R8
						rx_cnt  <= 5'h00;
						rx_bit  <= 4'h1;
					end else begin
						rx_cnt <= rx_cnt + 5'h01;    // R7
					end
				end else if (tick && rx_busy) begin
					if (rx_cnt == `DBU_OVERSAMPLE - 5'h01) begin
						rx_cnt <= 5'h00;             // R9
						if (rx_bit == rx_last) begin
							// Stop bit: complete character
							rx_busy            <= 1'b0;
							rx_bit             <= 4'h0;
							rx_holding_reg     <= rx_shift[7:0];         // R10
							char_received_flag <= 1'b1;                  // R10
							if (char_received_flag && !rhr_rd)
								overrun_flag <= 1'b1;                    // R11
							if (par_en && (rx_shift[8] != par_bit(rx_shift[7:0], check_bit_kind_field)))
								check_bit_error_flag <= 1'b1;            // R13
							if (!serial_in_pin)
								framing_flag <= 1'b1;                    // R15
							if (rx_off_pend) begin
								rx_on       <= 1'b0;                     // R5
								rx_off_pend <= 1'b0;
							end
						end else begin
							// Data bits LSB first, parity into bit 8
							if (rx_bit <= 4'd8)
								rx_shift <= {rx_shift[8], serial_in_pin, rx_shift[7:1]}; // R20
							else
								rx_shift[8] <= serial_in_pin;
							rx_bit <= rx_bit + 4'h1;
						end
					end else begin
						rx_cnt <= rx_cnt + 5'h01;
					end
				end
			end
		end
	end

	// Transmitter: holding register, shift register, line drive
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_on          <= 1'b0;                  // R17
			tx_off_pend    <= 1'b0;
			tx_state       <= TX_IDLE;
			tx_shift       <= 11'h7ff;
			tx_left        <= 4'h0;
			tx_cnt         <= 4'h0;
			hold_full      <= 1'b0;
			tx_holding_reg <= 8'h00;
			serial_out_pin <= 1'b1;                  // R26
		end else if (clk_en) begin
			if (tx_clr) begin
				tx_on          <= 1'b0;              // R19
				tx_off_pend    <= 1'b0;
				tx_state       <= TX_IDLE;
				hold_full      <= 1'b0;
				serial_out_pin <= 1'b1;              // R26
			end else begin
				if (tx_onc) begin
					tx_on       <= 1'b1;             // R17
					tx_off_pend <= 1'b0;
				end
				if (tx_offc) begin
					if (hold_full || tx_state != TX_IDLE)
						tx_off_pend <= 1'b1;         // R18
					else
						tx_on <= 1'b0;               // R18
				end
				if (thr_wr && tx_on) begin
					tx_holding_reg <= wdata[7:0];
					hold_full      <= 1'b1;          // R25
				end
				case (tx_state)
					TX_IDLE: begin
						serial_out_pin <= 1'b1;      // R26
						if (hold_full && tx_on && (baud_divisor_reg != 16'h0000)) begin // R2
							// Load frame: start, data, parity or stop, stop
							tx_shift  <= {1'b1, par_en ? par_bit(tx_holding_reg, check_bit_kind_field) : 1'b1,
								tx_holding_reg, 1'b0};                   // R20 R23
							tx_left   <= par_en ? 4'd11 : 4'd10;
							tx_cnt    <= 4'h0;
							hold_full <= thr_wr;                         // R25
							tx_state  <= TX_SEND;                        // R17
						end else if (tx_off_pend) begin
							tx_on       <= 1'b0;     // R18
							tx_off_pend <= 1'b0;
						end
					end
					TX_SEND: begin
						serial_out_pin <= tx_shift[0];                   // R20
						if (tick) begin
							if (tx_cnt == 4'hf) begin
								tx_shift <= {1'b1, tx_shift[10:1]};
								tx_left  <= tx_left - 4'h1;
								if (tx_left == 4'h1)
									tx_state <= TX_IDLE;                 // R24
							end
							tx_cnt <= tx_cnt + 4'h1;
						end
					end
					default: tx_state <= TX_IDLE;
				endcase
			end
		end
	end

endmodule

/* verification/dbu_host.sv */
// Remote serial host: sends frames to the port and captures its frames.
// Assumes a divisor of one, so a bit lasts sixteen master clocks.
`timescale 1ns/1ns
module dbu_host (
	input  wire  clk,
	input  wire  line_in,
	output logic line_out
);
	int         bit_clks = 16; // Clocks per bit
	logic       has_par = 1'b0; // Frame carries a check bit
	logic [7:0] rx_byte;        // Last captured data
	logic       rx_par;         // Last captured check bit
	logic       rx_stop;        // Last captured stop level
	int         rx_count = 0;   // Frames captured

	initial line_out = 1'b1;

	// Hold one level for c clocks
	task put(input logic b, input int c);
		line_out <= b;
		repeat (c) @(posedge clk);
	endtask

	// A low stop is held only past mid-bit, so it cannot pose as a start
	task send(input logic [7:0] d, input logic p, input logic s);
		@(posedge clk);
		put(1'b0, bit_clks);
		for (int i = 0; i < 8; i++) put(d[i], bit_clks);
		if (has_par) put(p, bit_clks);
		put(s, s ? bit_clks : bit_clks / 2 + 4);
		put(1'b1, bit_clks);
	endtask

	// Short space on the line
	task glitch(input int c);
		@(posedge clk);
		put(1'b0, c);
		line_out <= 1'b1;
	endtask

	// Capture each frame at mid-bit
	always begin
		@(negedge line_in);
		repeat (bit_clks / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(posedge clk);
			rx_byte[i] = line_in;
		end
		if (has_par) begin
			repeat (bit_clks) @(posedge clk);
			rx_par = line_in;
		end
		repeat (bit_clks) @(posedge clk);
		rx_stop = line_in;
		rx_count++;
	end
endmodule

/* verification/dbu_properties.sv */
// Checker for the debug serial port, watching only its top ports.
// Assumes one clock and the register offsets of the port's constant header.
`timescale 1ns/1ns
module dbu_properties (
	input wire        clk,
	input wire        reset_n,
	input wire        clk_en,
	input wire [7:0]  addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire        serial_in_pin,
	input wire        serial_out_pin,
	input wire        mailbox_read_full,
	input wire        mailbox_write_full,
	input wire        irq
);
	logic [31:0] mask_h;    // Mirror of the interrupt mask
	logic        div_zero;  // Divisor holds zero
	logic        flg_q;     // Flags read answered now
	logic        clr_since; // Clear command since last flags read
	logic [2:0]  err_seen;  // Error bits at last flags read

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Mirror writes and remember error bits seen by software
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_h <= 32'h0;
			div_zero <= 1'b1;
			flg_q <= 1'b0;
			clr_since <= 1'b0;
			err_seen <= 3'h0;
		end else if (clk_en) begin
			flg_q <= rd && addr == 8'h14;
			if (flg_q) begin
				err_seen <= rdata[7:5];
				clr_since <= 1'b0;
			end
			// A clear after the snapshot wins
			if (wr && addr == 8'h00 && wdata[8])
				clr_since <= 1'b1;
			if (wr && addr == 8'h08)
				mask_h <= mask_h | wdata;
			if (wr && addr == 8'h0c)
				mask_h <= mask_h & ~wdata;
			if (wr && addr == 8'h20)
				div_zero <= wdata[15:0] == 16'h0000;
		end
	end

	// Flags read, ending in the answer cycle
	sequence s_flg;
		(rd && clk_en && addr == 8'h14) ##1 1'b1;
	endsequence

	property p_rd_idle;
		clk_en && !rd ##1 clk_en |-> rdata == 32'h0;
	endproperty
	property p_mbx;
		s_flg |-> rdata[31:30] == {$past(mailbox_write_full), $past(mailbox_read_full)};
	endproperty
	property p_irq_mask;
		irq |-> mask_h != 32'h0;
	endproperty
	property p_irq_mbx;
		mask_h[31] && mailbox_write_full |-> irq;
	endproperty
	property p_tx_clr;
		clk_en && wr && addr == 8'h00 && wdata[3] && !wdata[6] |-> ##[2:3] serial_out_pin;
	endproperty
	property p_div_zero;
		div_zero && $past(div_zero) |-> $stable(serial_out_pin);
	endproperty
	property p_err_sticky;
		flg_q && !clr_since |-> (rdata[7:5] & err_seen) == err_seen;
	endproperty
	property p_all_sent;
		s_flg ##0 rdata[9] |-> $past(serial_out_pin);
	endproperty

	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	a_mbx: assert property (p_mbx) else $error("mailbox bits wrong");
	a_irq_mask: assert property (p_irq_mask) else $error("irq with empty mask");
	a_irq_mbx: assert property (p_irq_mbx) else $error("mailbox irq missing");
	a_tx_clr: assert property (p_tx_clr) else $error("line low after tx clear");
	a_div_zero: assert property (p_div_zero) else $error("line moved at divisor zero");
	a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");
	a_all_sent: assert property (p_all_sent) else $error("all sent while line low");
endmodule

bind dbu_port dbu_properties chk_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_in_pin(serial_in_pin),
	.serial_out_pin(serial_out_pin), .mailbox_read_full(mailbox_read_full),
	.mailbox_write_full(mailbox_write_full), .irq(irq));

/* verification/tb.sv */
// Register-level test of the debug serial port against the serial host.
// Assumes the port's register map and a divisor of one once set.
`timescale 1ns/1ns
module tb;
	logic        clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, mbr = 1'b0, mbw = 1'b0;
	logic [7:0]  addr = 8'h00, d;
	logic [31:0] wdata = 32'h0;
	logic        p;
	logic        ce = 1'b1;
	wire  [31:0] rdata;
	wire         sin, sout, irq;
	int          err_count = 0, check_count = 0, n, k;

	dbu_port uut (.clk(clk), .reset_n(reset_n), .clk_en(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .serial_in_pin(sin), .serial_out_pin(sout),
		.mailbox_read_full(mbr), .mailbox_write_full(mbw), .irq(irq));
	dbu_host host (.clk(clk), .line_in(sout), .line_out(sin));

	always #5 clk = ~clk;

	task stop_test;
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask
	task wait_rx(input int c);
		for (int i = 0; i < 3000 && host.rx_count < c; i++) @(posedge clk);
		if (host.rx_count < c) begin
			err_count++;
			stop_test;
		end
	endtask

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rchk(8'h14, 32'h3, 32'h0);
		rchk(8'h04, 32'he00, 32'h800);
		rchk(8'h20, 32'hffff, 32'h0);
		rchk(8'h24, 32'hffffffff, 32'h0);
		wreg(8'h00, 32'h50);
		host.send(8'h5a, 1'b0, 1'b1);
		rchk(8'h14, 32'h1, 32'h0);
		wreg(8'h20, 32'h1);
		rchk(8'h20, 32'hffff, 32'h1);
		host.glitch(7);
		repeat (40) @(posedge clk);
		rchk(8'h14, 32'h1, 32'h0);
		// Every check-bit kind, both directions
		for (k = 0; k < 5; k++) begin
			d = 8'h35 + k[7:0] * 8'h11;
			p = (k == 0) ? ^d : (k == 1) ? ~^d : (k == 3);
			host.has_par = k < 4;
			wreg(8'h04, k << 9);
			host.send(d, p, 1'b1);
			rchk(8'h18, 32'hff, {24'h0, d});
			rchk(8'h14, 32'he1, 32'h0);
			n = host.rx_count;
			wreg(8'h1c, {24'h0, d});
			wait_rx(n + 1);
			chk(host.rx_byte, d);
			if (k < 4) chk(host.rx_par, p);
			chk(host.rx_stop, 1'b1);
		end
		// Bad check bit and low stop, then overrun
		wreg(8'h04, 32'h0);
		host.has_par = 1'b1;
		host.send(8'h0f, 1'b1, 1'b0);
		host.send(8'h3c, 1'b0, 1'b1);
		rchk(8'h14, 32'he1, 32'he1);
		wreg(8'h00, 32'h100);
		rchk(8'h14, 32'he1, 32'h01);
		rchk(8'h18, 32'hff, 32'h3c);
		rchk(8'h14, 32'h1, 32'h0);
		// Receiver clear and disable in mid-frame
		fork
			host.send(8'h77, 1'b0, 1'b1);
			begin repeat (60) @(posedge clk); wreg(8'h00, 32'h4); end
		join
		rchk(8'h14, 32'h1, 32'h0);
		host.send(8'h77, 1'b0, 1'b1);
		rchk(8'h14, 32'h1, 32'h0);
		wreg(8'h00, 32'h10);
		fork
			host.send(8'h99, 1'b0, 1'b1);
			begin repeat (60) @(posedge clk); wreg(8'h00, 32'h20); end
		join
		rchk(8'h18, 32'hff, 32'h99);
		host.send(8'h11, 1'b0, 1'b1);
		rchk(8'h14, 32'h1, 32'h0);
		wreg(8'h00, 32'h10);
		// Transmitter disable with a held character
		n = host.rx_count;
		wreg(8'h1c, 32'ha1);
		wreg(8'h1c, 32'hb2);
		rchk(8'h14, 32'h2, 32'h0);
		wreg(8'h00, 32'h80);
		wait_rx(n + 2);
		chk(host.rx_byte, 8'hb2);
		repeat (20) @(posedge clk);
		rchk(8'h14, 32'h202, 32'h0);
		wreg(8'h1c, 32'h55);
		repeat (400) @(posedge clk);
		chk(host.rx_count, n + 2);
		wreg(8'h00, 32'h40);
		rchk(8'h14, 32'h202, 32'h202);
		// Transmitter clear in mid-frame
		wreg(8'h1c, 32'hf0);
		repeat (50) @(posedge clk);
		wreg(8'h00, 32'h8);
		repeat (300) @(posedge clk);
		chk(sout, 1'b1);
		rchk(8'h14, 32'h2, 32'h0);
		// Clock enable low: a format write is ignored
		ce <= 1'b0;
		wreg(8'h04, 32'h200);
		ce <= 1'b1;
		rchk(8'h04, 32'he00, 32'h0);
		// Mailbox levels and their interrupt
		mbw <= 1'b1;
		mbr <= 1'b1;
		wreg(8'h08, 32'h80000000);
		#1 chk(irq, 1'b1);
		rchk(8'h14, 32'hc0000000, 32'hc0000000);
		wreg(8'h0c, 32'h80000000);
		#1 chk(irq, 1'b0);
		stop_test;
	end
endmodule
